// ==== logic/delim_pulse_delay.v ====
// delimiter pulse delay line in whole phase steps
`timescale 1ns/1ps
`include "wake_sfd_consts.vh"
module delim_pulse_delay #(
  parameter STEPS = `PHASE_STEPS
) (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // pulse and phase
  input  wire       pulse_in,
  input  wire [3:0] phase,
  output reg        pulse_out
);
  localparam STEP_CYC = (`PHASE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam LEN      = STEP_CYC * STEPS;

  reg [LEN-1:0] line_q;

  // shift the pulse along and pick the tap for the phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q    <= {LEN{1'b0}};
      pulse_out <= 1'b0;
    end else begin
      line_q <= {line_q[LEN-2:0], pulse_in};
      if (phase == 4'h0)
        pulse_out <= pulse_in;
      else
        pulse_out <= line_q[phase * STEP_CYC - 1];
    end
  end
endmodule

// ==== logic/wake_frame_and_sfd_detect.v ====
// wake frame detector, delimiter pulses and skew report with apb registers
`timescale 1ns/1ps
`include "wake_sfd_consts.vh"
module wake_frame_and_sfd_detect #(
  parameter PULSE_CYCLES = 8,
  parameter PAT_BYTES    = 64
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // received byte stream
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_sof,
  input  wire        rx_eof,
  // delimiter events and link state
  input  wire        tx_delimiter_pulse_in,
  input  wire        rx_delimiter_pulse_in,
  input  wire [1:0]  link_speed,
  input  wire        link_up,
  input  wire        link_master,
  input  wire [3:0]  align_skew,
  // outputs
  output reg  [1:0]  gpio_out,
  output reg         soft_restart
);
  localparam S_SYNC = 2'd0;
  localparam S_ADDR = 2'd1;
  localparam S_PASS = 2'd2;
  localparam S_DONE = 2'd3;

  // ************************************************************
  // helpers
  // ************************************************************
  function [7:0] pick_byte;
    input [47:0] v;
    input [2:0]  i;
    begin
      pick_byte = v[47 - 8*i -: 8];
    end
  endfunction

  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      k;
    reg   [31:0] r;
    begin
      r = c;
      for (k = 0; k < 8; k = k + 1) begin
        if (r[0] ^ d[k])
          r = (r >> 1) ^ `CRC_POLY;
        else
          r = r >> 1;
      end
      crc_byte = r;
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  reg [15:0] cfg_q, sts_q, mux_q, ctl_q, sync_q, skew_q, phase_q;
  reg [47:0] station_q, password_q;
  reg [7:0]  pat_mem [0:PAT_BYTES-1];
  reg [31:0] rdata_d;
  reg        hit_d;

  wire [9:0] idx    = paddr[11:2];
  wire       setup  = psel & ~penable;
  wire       access = psel & penable;
  wire       wr     = access & pwrite & ~pslverr;
  wire       rd     = access & ~pwrite & ~pslverr;

  assign pready  = 1'b1;
  assign pslverr = access & (~hit_d | (paddr[1:0] != 2'b00));

  // read decode, unmapped reads give zero
  always @* begin
    hit_d   = 1'b1;
    rdata_d = 32'h0000_0000;
    if (idx == `IDX_SKEW_STATUS)
      rdata_d[15:0] = skew_q;
    else if (idx == `IDX_PHY_CONTROL)
      rdata_d[15:0] = ctl_q;
    else if (idx == `IDX_SYNC_FIFO)
      rdata_d[15:0] = sync_q;
    else if (idx == `IDX_RX_FILT_CFG)
      rdata_d[15:0] = cfg_q;
    else if (idx == `IDX_RX_FILT_STS)
      rdata_d[15:0] = sts_q;
    else if (idx == `IDX_PIN_MUX)
      rdata_d[15:0] = mux_q;
    else if (idx >= `IDX_STATION0 && idx < `IDX_STATION0 + 10'h3)
      rdata_d[15:0] = station_q[47 - 16*(idx - `IDX_STATION0) -: 16];
    else if (idx >= `IDX_PASSWORD0 && idx < `IDX_PASSWORD0 + 10'h3)
      rdata_d[15:0] = password_q[47 - 16*(idx - `IDX_PASSWORD0) -: 16];
    else if (idx == `IDX_PATTERN_WR)
      rdata_d = 32'h0000_0000;
    else if (idx == `IDX_PHASE)
      rdata_d[15:0] = phase_q;
    else
      hit_d = 1'b0;
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= (paddr[1:0] == 2'b00) ? rdata_d : 32'h0000_0000;
  end

  // software writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q        <= `REG_RESET;
      mux_q        <= `REG_RESET;
      ctl_q        <= `REG_RESET;
      sync_q       <= `REG_RESET;
      phase_q      <= `REG_RESET;
      station_q    <= 48'h0000_0000_0000;
      password_q   <= 48'h0000_0000_0000;
      soft_restart <= 1'b0;
    end else begin
      soft_restart <= 1'b0;
      if (wr) begin
        if (idx == `IDX_PHY_CONTROL) begin
          ctl_q                    <= pwdata[15:0];
          ctl_q[`CTL_SOFT_RESTART] <= 1'b0;
          soft_restart             <= pwdata[`CTL_SOFT_RESTART];
        end else if (idx == `IDX_SYNC_FIFO)
          sync_q <= pwdata[15:0];
        else if (idx == `IDX_RX_FILT_CFG)
          cfg_q <= pwdata[15:0];
        else if (idx == `IDX_PIN_MUX)
          mux_q <= pwdata[15:0];
        else if (idx >= `IDX_STATION0 && idx < `IDX_STATION0 + 10'h3)
          station_q[47 - 16*(idx - `IDX_STATION0) -: 16] <= pwdata[15:0];
        else if (idx >= `IDX_PASSWORD0 && idx < `IDX_PASSWORD0 + 10'h3)
          password_q[47 - 16*(idx - `IDX_PASSWORD0) -: 16] <= pwdata[15:0];
        else if (idx == `IDX_PHASE)
          phase_q <= pwdata[15:0];
      end
    end
  end

  // pattern bytes, index in bits 13:8 and byte in 7:0
  always @(posedge pclk) begin
    if (wr && idx == `IDX_PATTERN_WR)
      pat_mem[pwdata[13:8]] <= pwdata[7:0];
  end

  // ************************************************************
  // wake frame scan
  // ************************************************************
  reg [31:0] crc_q, crc_b, crc_d;
  reg [6:0]  pos_q, pos_b, pos_d;
  reg [1:0]  st_q, st_b, st_d;
  reg [2:0]  ff_q, ff_b, ff_d, bi_q, bi_b, bi_d;
  reg [3:0]  cpy_q, cpy_b, cpy_d;
  reg        own_q, own_b, own_d, bc_q, bc_b, bc_d;
  reg        pok_q, pok_b, pok_d, phit_q, phit_b, phit_d;
  reg        ev_magic, ev_pat, ev_bad, addr_ok, crc_good;
  wire [7:0] b = rx_data;

  // next state of the scan for one received byte
  always @* begin
    crc_b  = rx_sof ? `CRC_INIT : crc_q;
    pos_b  = rx_sof ? 7'd0 : pos_q;
    st_b   = rx_sof ? S_SYNC : st_q;
    ff_b   = rx_sof ? 3'd0 : ff_q;
    bi_b   = rx_sof ? 3'd0 : bi_q;
    cpy_b  = rx_sof ? 4'd0 : cpy_q;
    own_b  = rx_sof | own_q;
    bc_b   = rx_sof | bc_q;
    pok_b  = rx_sof | pok_q;
    phit_b = rx_sof ? 1'b0 : phit_q;
    if (!rx_sof) begin
      own_b = own_q;
      bc_b  = bc_q;
      pok_b = pok_q;
    end
    crc_d  = crc_b;
    pos_d  = pos_b;
    st_d   = st_b;
    ff_d   = ff_b;
    bi_d   = bi_b;
    cpy_d  = cpy_b;
    own_d  = own_b;
    bc_d   = bc_b;
    pok_d  = pok_b;
    phit_d = phit_b;
    if (rx_valid) begin
      crc_d = crc_byte(crc_b, b);
      if (pos_b != PAT_BYTES[6:0])
        pos_d = pos_b + 7'd1;
      // destination of the frame
      if (pos_b < 7'd6) begin
        own_d = own_b & (b == pick_byte(station_q, pos_b[2:0]));
        bc_d  = bc_b & (b == `SYNC_BYTE);
      end
      // fixed pattern over the head of the frame
      if (pos_b < PAT_BYTES[6:0]) begin
        pok_d = pok_b & (b == pat_mem[pos_b[5:0]]);
        if (pos_b == PAT_BYTES[6:0] - 7'd1)
          phit_d = pok_d;
      end
      // sync run then address copies, from any position
      case (st_b)
        S_SYNC: begin
          if (b == `SYNC_BYTE) begin
            if (ff_b != `SYNC_RUN)
              ff_d = ff_b + 3'd1;
          end else if (ff_b == `SYNC_RUN && b == pick_byte(station_q, 3'd0)) begin
            st_d  = S_ADDR;
            bi_d  = 3'd1;
            cpy_d = 4'd0;
            ff_d  = 3'd0;
          end else
            ff_d = 3'd0;
        end
        S_ADDR: begin
          if (b == pick_byte(station_q, bi_b)) begin
            if (bi_b == `LAST_ADDR_BYTE) begin
              bi_d = 3'd0;
              if (cpy_b == `ADDR_COPIES)
                st_d = cfg_q[`CFG_PASSWORD_EN] ? S_PASS : S_DONE;
              else
                cpy_d = cpy_b + 4'd1;
            end else
              bi_d = bi_b + 3'd1;
          end else begin
            st_d = S_SYNC;
            ff_d = (b == `SYNC_BYTE) ? 3'd1 : 3'd0;
          end
        end
        S_PASS: begin
          if (b == pick_byte(password_q, bi_b)) begin
            if (bi_b == `LAST_ADDR_BYTE)
              st_d = S_DONE;
            else
              bi_d = bi_b + 3'd1;
          end else begin
            st_d = S_SYNC;
            ff_d = (b == `SYNC_BYTE) ? 3'd1 : 3'd0;
          end
        end
        default: st_d = S_DONE;
      endcase
    end
    // verdict at the last byte of the frame
    crc_good = (crc_d == `CRC_RESIDUE);
    addr_ok  = (own_d & cfg_q[`CFG_UCAST_EN]) | (bc_d & cfg_q[`CFG_BCAST_EN]);
    ev_magic = rx_valid & rx_eof & addr_ok & crc_good & cfg_q[`CFG_MAGIC_EN] & (st_d == S_DONE);
    ev_pat   = rx_valid & rx_eof & addr_ok & crc_good & cfg_q[`CFG_PATTERN_EN] & phit_d;
    ev_bad   = rx_valid & rx_eof & addr_ok & ~crc_good &
               ((cfg_q[`CFG_MAGIC_EN] & (st_d == S_DONE)) | (cfg_q[`CFG_PATTERN_EN] & phit_d));
  end

  // scan state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q  <= `CRC_INIT;
      pos_q  <= 7'd0;
      st_q   <= S_SYNC;
      ff_q   <= 3'd0;
      bi_q   <= 3'd0;
      cpy_q  <= 4'd0;
      own_q  <= 1'b0;
      bc_q   <= 1'b0;
      pok_q  <= 1'b0;
      phit_q <= 1'b0;
    end else begin
      crc_q  <= crc_d;
      pos_q  <= pos_d;
      st_q   <= st_d;
      ff_q   <= ff_d;
      bi_q   <= bi_d;
      cpy_q  <= cpy_d;
      own_q  <= own_d;
      bc_q   <= bc_d;
      pok_q  <= pok_d;
      phit_q <= phit_d;
    end
  end

  // ************************************************************
  // wake status and pin signalling
  // ************************************************************
  reg  [7:0] pulse_cnt_q;
  wire       sts_rd = rd & (idx == `IDX_RX_FILT_STS);
  wire       wake_any = ev_magic | ev_pat;

  // sticky status, cleared by reading, a new event wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q       <= `REG_RESET;
      pulse_cnt_q <= 8'h00;
    end else begin
      sts_q[`STS_MAGIC]   <= ev_magic | (sts_q[`STS_MAGIC] & ~sts_rd);
      sts_q[`STS_PATTERN] <= ev_pat | (sts_q[`STS_PATTERN] & ~sts_rd);
      sts_q[`STS_BAD_CRC] <= ev_bad | (sts_q[`STS_BAD_CRC] & ~sts_rd);
      if (wake_any)
        pulse_cnt_q <= PULSE_CYCLES[7:0];
      else if (pulse_cnt_q != 8'h00)
        pulse_cnt_q <= pulse_cnt_q - 8'h01;
    end
  end

  wire wake_sig = cfg_q[`CFG_WAKE_LEVEL] ? (sts_q[`STS_MAGIC] | sts_q[`STS_PATTERN])
                                         : (pulse_cnt_q != 8'h00);

  // ************************************************************
  // delimiter pulses
  // ************************************************************
  wire tx_delimiter_pulse;
  wire rx_delimiter_pulse;

  delim_pulse_delay #(.STEPS(`PHASE_STEPS)) u_tx_delay (
    .pclk      (pclk),
    .presetn   (presetn),
    .pulse_in  (tx_delimiter_pulse_in),
    .phase     (phase_q[3:0]),
    .pulse_out (tx_delimiter_pulse)
  );

  delim_pulse_delay #(.STEPS(`PHASE_STEPS)) u_rx_delay (
    .pclk      (pclk),
    .presetn   (presetn),
    .pulse_in  (rx_delimiter_pulse_in),
    .phase     (phase_q[7:4]),
    .pulse_out (rx_delimiter_pulse)
  );

  function pin_src;
    input [3:0] sel;
    input       ext_en;
    begin
      if (sel == `SEL_WAKE)
        pin_src = wake_sig;
      else if (sel == `SEL_TX_DELIM)
        pin_src = ext_en & tx_delimiter_pulse;
      else if (sel == `SEL_RX_DELIM)
        pin_src = ext_en & rx_delimiter_pulse;
      else
        pin_src = 1'b0;
    end
  endfunction

  // pin multiplexer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gpio_out <= 2'b00;
    else begin
      gpio_out[0] <= pin_src(mux_q[3:0], cfg_q[`CFG_EXT_HOST_EN]);
      gpio_out[1] <= pin_src(mux_q[7:4], cfg_q[`CFG_EXT_HOST_EN]);
    end
  end

  // ************************************************************
  // receive alignment skew report
  // ************************************************************
  reg link_q;

  // latched once when a 1000 Mb link forms while sync_q holds SYNC_FIFO_MAGIC, held until the link drops or leaves 1000 Mb
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= 1'b0;
      skew_q <= `REG_RESET;
    end else begin
      link_q <= link_up;
      if (!link_up || link_speed != `SPD_1000)
        skew_q <= `REG_RESET;
      else if (!link_q && sync_q == `SYNC_FIFO_MAGIC) begin
        if (link_master)
          skew_q <= {8'h00, align_skew, 4'h0};
        else
          skew_q <= {12'h000, align_skew};
      end
    end
  end
endmodule

// ==== pkg/wake_sfd_consts.vh ====
// constants for the wake frame and delimiter pulse block
`ifndef WAKE_SFD_CONSTS_VH
`define WAKE_SFD_CONSTS_VH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define IDX_SKEW_STATUS   10'h055
`define IDX_PHY_CONTROL   10'h01f
`define IDX_SYNC_FIFO     10'h0e9
`define IDX_RX_FILT_CFG   10'h134
`define IDX_RX_FILT_STS   10'h135
`define IDX_PIN_MUX       10'h1e0
`define IDX_STATION0      10'h140
`define IDX_PASSWORD0     10'h143
`define IDX_PATTERN_WR    10'h146
`define IDX_PHASE         10'h147

// ************************************************************
// fields
// ************************************************************
`define CFG_MAGIC_EN      0
`define CFG_PATTERN_EN    1
`define CFG_BCAST_EN      2
`define CFG_UCAST_EN      3
`define CFG_PASSWORD_EN   4
`define CFG_EXT_HOST_EN   5
`define CFG_WAKE_LEVEL    6
`define STS_MAGIC         0
`define STS_PATTERN       1
`define STS_BAD_CRC       2
`define CTL_SOFT_RESTART  14
`define SEL_OFF           4'h0
`define SEL_WAKE          4'h1
`define SEL_TX_DELIM      4'h2
`define SEL_RX_DELIM      4'h3
`define SPD_1000          2'h2

// ************************************************************
// values
// ************************************************************
`define SYNC_FIFO_MAGIC   16'hdf22
`define SYNC_BYTE         8'hff
`define SYNC_RUN          3'h6
`define ADDR_COPIES       4'hf
`define LAST_ADDR_BYTE    3'h5
`define CRC_INIT          32'hffff_ffff
`define CRC_POLY          32'hedb8_8320
`define CRC_RESIDUE       32'hdebb_20e3
`define REG_RESET         16'h0000
`define PHASE_STEP_NS     8
`define CLK_PERIOD_NS     4
`define PHASE_STEPS       16

`endif

// ==== test/rx_byte_source.sv ====
// link-side byte source that feeds received frames with their check sequence
`timescale 1ns/1ps
module rx_byte_source (
  // clock
  input  wire       pclk,
  // received byte stream
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        rx_sof,
  output reg        rx_eof
);
  reg [7:0] fb [0:255];

  // idle level: valid low, data inverted so nothing stale lingers
  task idle(input [7:0] v);
    begin
      rx_valid <= 1'b0;
      rx_sof   <= 1'b0;
      rx_eof   <= 1'b0;
      rx_data  <= v;
    end
  endtask

  // stream n bytes plus check sequence, gap idle cycles after each byte
  task send(input integer n, input integer gap, input bad);
    integer    i;
    integer    k;
    reg [31:0] c;
    begin
      c = 32'hffff_ffff;
      for (i = 0; i < n + 4; i = i + 1) begin
        if (i == n) c = ~c ^ {31'h0000_0000, bad}; // bad flips one bit
        if (i >= n) fb[i] = c[8 * (i - n) +: 8];
        else begin
          c = c ^ {24'h00_0000, fb[i]};
          for (k = 0; k < 8; k = k + 1) c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
        end
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_data  <= fb[i];
        rx_sof   <= (i == 0);
        rx_eof   <= (i == n + 3);
        for (k = 0; k < gap; k = k + 1) begin
          @(posedge pclk);
          idle(~fb[i]);
        end
      end
      @(posedge pclk);
      idle(~fb[n + 3]);
    end
  endtask

  // quiet lines until the first frame
  initial begin
    idle(8'h00);
  end
endmodule

// ==== test/wake_frame_and_sfd_detect_tb.sv ====
// self-checking bench for the wake frame and delimiter block
`timescale 1ns/1ps
module wake_frame_and_sfd_detect_tb;
  localparam PULSE = 8;
  reg         pclk        = 1'b0;
  reg         presetn     = 1'b0;
  reg         psel        = 1'b0;
  reg         penable     = 1'b0;
  reg         pwrite      = 1'b0;
  reg  [11:0] paddr       = 12'h000;
  reg  [31:0] pwdata      = 32'h0000_0000;
  reg         tx_delimiter_pulse_in   = 1'b0;
  reg         rx_delimiter_pulse_in   = 1'b0;
  reg  [1:0]  link_speed  = 2'h0;
  reg         link_up     = 1'b0;
  reg         link_master = 1'b0;
  reg  [3:0]  align_skew  = 4'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, rx_valid, rx_sof, rx_eof, soft_restart;
  wire [7:0]  rx_data;
  wire [1:0]  gpio_out;
  integer     fails = 0;
  integer     check_count = 0;
  integer     cycles = 0;
  integer     restarts = 0;
  integer     hi = 0;
  integer     i, n, s;
  reg  [31:0] rd;
  reg         er;
  reg  [11:0] seen;
  reg  [63:0] row [0:14];

  wake_frame_and_sfd_detect #(.PULSE_CYCLES(PULSE), .PAT_BYTES(64)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .tx_delimiter_pulse_in(tx_delimiter_pulse_in), .rx_delimiter_pulse_in(rx_delimiter_pulse_in), .link_speed(link_speed),
    .link_up(link_up), .link_master(link_master), .align_skew(align_skew), .gpio_out(gpio_out),
    .soft_restart(soft_restart));
  rx_byte_source src (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof));

  // clock
  always #2 pclk = ~pclk;

  // cycle ceiling, restart pulses and wake pin high time
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (soft_restart === 1'b1) restarts <= restarts + 1;
    if (gpio_out[0] === 1'b1) hi <= hi + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_of_test;
    end
  end

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // one bus transfer, held until pready is seen high
  task apb(input w, input [11:0] a, input [15:0] d);
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task put(input [7:0] v);
    begin
      src.fb[n] = v;
      n = n + 1;
    end
  endtask

  // wake frame: destination, source and misc, sync run, address copies, password
  task mk(input bc, input integer nsync, input integer copies, input pw);
    integer j;
    begin
      n = 0;
      for (j = 0; j < 6; j = j + 1) put(bc ? 8'hff : 8'h11 * (j + 1));
      for (j = 0; j < 9; j = j + 1) put(8'h40 + j);
      for (j = 0; j < nsync; j = j + 1) put(8'hff);
      for (j = 0; j < copies * 6; j = j + 1) put(8'h11 * (j % 6 + 1));
      for (j = 0; j < 6 && pw; j = j + 1) put(8'h2a + j);
      for (j = 0; j < 4; j = j + 1) put(8'h5a);
    end
  endtask

  // send, wait, read status twice: flags then cleared
  task run(input integer gap, input bad, input [15:0] exp);
    begin
      src.send(n, gap, bad);
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h4d4, 16'h0000);
      chk(rd, {16'h0000, exp});
      apb(1'b0, 12'h4d4, 16'h0000);
      chk(rd, 32'h0000_0000);
    end
  endtask

  // both delimiter events at once, pins sampled for six cycles
  task pulse;
    integer k;
    begin
      @(posedge pclk);
      tx_delimiter_pulse_in <= 1'b1;
      rx_delimiter_pulse_in <= 1'b1;
      @(posedge pclk);
      tx_delimiter_pulse_in <= 1'b0;
      rx_delimiter_pulse_in <= 1'b0;
      for (k = 0; k < 6; k = k + 1) begin
        #1 seen[2 * k +: 2] = gpio_out;
        @(posedge pclk);
      end
    end
  endtask

  // main sequence
  initial begin
    row[0]  = 64'h04d0_0009_0009_0000; // wake and unicast on
    row[1]  = 64'h0780_0001_0001_0000; // wake on pin 0
    row[2]  = 64'h03a4_df22_df22_0000;
    row[3]  = 64'h051c_0001_0001_0000;
    row[4]  = 64'h0500_1122_1122_0000;
    row[5]  = 64'h0504_3344_3344_0000;
    row[6]  = 64'h0508_5566_5566_0000;
    row[7]  = 64'h050c_2a2b_2a2b_0000;
    row[8]  = 64'h0510_2c2d_2c2d_0000;
    row[9]  = 64'h0514_2e2f_2e2f_0000;
    row[10] = 64'h04d4_0007_0000_0000; // read only
    row[11] = 64'h0154_00ff_0000_0000; // read only
    row[12] = 64'h007c_4000_0000_0000; // restart bit reads 0
    row[13] = 64'h0600_1234_0000_0001; // unmapped
    row[14] = 64'h04d2_1234_0000_0001; // misaligned
    seen = 12'h000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 15; i = i + 1) begin
      apb(1'b0, row[i][59:48], 16'h0000);
      chk(rd, 32'h0000_0000);
      chk(er, row[i][0]);
      apb(1'b1, row[i][59:48], row[i][47:32]);
      apb(1'b0, row[i][59:48], 16'h0000);
      chk(rd, {16'h0000, row[i][31:16]});
    end
    chk(restarts, 1);
    for (s = 0; s < 3; s = s + 1) begin
      link_speed <= s[1:0];
      mk(1'b0, 6, 16, 1'b0);
      run(2 - s, 1'b0, 16'h0001);
    end
    chk(hi, 3 * PULSE);
    mk(1'b0, 6, 15, 1'b0);
    run(0, 1'b0, 16'h0000);
    mk(1'b0, 5, 16, 1'b0);
    run(0, 1'b0, 16'h0000);
    mk(1'b0, 6, 16, 1'b0);
    run(0, 1'b1, 16'h0004);
    mk(1'b1, 6, 16, 1'b0);
    run(0, 1'b0, 16'h0000);
    apb(1'b1, 12'h4d0, 16'h000d);
    run(0, 1'b0, 16'h0001);
    apb(1'b1, 12'h4d0, 16'h0019);
    mk(1'b0, 6, 16, 1'b0);
    run(0, 1'b0, 16'h0000);
    mk(1'b0, 6, 16, 1'b1);
    run(0, 1'b0, 16'h0001);
    apb(1'b1, 12'h4d0, 16'h0008);
    run(0, 1'b0, 16'h0000);
    for (i = 0; i < 64; i = i + 1) apb(1'b1, 12'h518, {2'b00, i[5:0], src.fb[i]});
    apb(1'b1, 12'h4d0, 16'h000a);
    run(0, 1'b0, 16'h0002);
    src.fb[63] = 8'h00;
    run(0, 1'b0, 16'h0000);
    apb(1'b1, 12'h4d0, 16'h0049);
    mk(1'b0, 6, 16, 1'b0);
    src.send(n, 0, 1'b0);
    repeat (20) @(posedge pclk);
    chk(gpio_out[0], 1);
    apb(1'b0, 12'h4d4, 16'h0000);
    repeat (3) @(posedge pclk);
    chk(gpio_out[0], 0);
    apb(1'b1, 12'h780, 16'h0032);
    for (s = 0; s < 2; s = s + 1) begin
      apb(1'b1, 12'h4d0, s ? 16'h0020 : 16'h0000);
      pulse;
      chk(seen, s ? 12'h048 : 12'h000);
    end
    link_speed  <= 2'h2;
    link_master <= 1'b1;
    align_skew  <= 4'h3;
    link_up     <= 1'b1;
    apb(1'b0, 12'h154, 16'h0000);
    chk(rd, 32'h0000_0030);
    align_skew <= 4'h7;
    apb(1'b0, 12'h154, 16'h0000);
    chk(rd, 32'h0000_0030);
    link_up     <= 1'b0;
    link_master <= 1'b0;
    repeat (2) @(posedge pclk);
    link_up <= 1'b1;
    apb(1'b0, 12'h154, 16'h0000);
    chk(rd, 32'h0000_0007);
    link_up    <= 1'b0;
    link_speed <= 2'h1;
    repeat (2) @(posedge pclk);
    link_up <= 1'b1;
    apb(1'b0, 12'h154, 16'h0000);
    chk(rd, 32'h0000_0000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({gpio_out, soft_restart}, 0);
    presetn <= 1'b1;
    apb(1'b0, 12'h4d0, 16'h0000);
    chk(rd, 32'h0000_0000);
    end_of_test;
  end
endmodule

bind wake_frame_and_sfd_detect wake_sfd_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_eof(rx_eof),
  .tx_delimiter_pulse_in(tx_delimiter_pulse_in), .rx_delimiter_pulse_in(rx_delimiter_pulse_in), .gpio_out(gpio_out), .soft_restart(soft_restart));

// ==== test/wake_sfd_checker.sv ====
// port assertions for the wake and delimiter block
`timescale 1ns/1ps
module wake_sfd_checker #(
  parameter PULSE_CYCLES = 8
) (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // stream, events and pins
  input wire        rx_valid,
  input wire        rx_eof,
  input wire        tx_delimiter_pulse_in,
  input wire        rx_delimiter_pulse_in,
  input wire [1:0]  gpio_out,
  input wire        soft_restart
);
  reg  [7:0] mux_q;
  reg  [6:0] cfg_q;
  reg  [7:0] ph_q;
  reg  [7:0] hi_q;
  wire       wr = psel && penable && pwrite && pready;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow of bus writes and high time of pin 0
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_q <= 8'h00;
      cfg_q <= 7'h00;
      ph_q  <= 8'h00;
      hi_q  <= 8'h00;
    end else begin
      if (wr && paddr == 12'h780) mux_q <= pwdata[7:0];
      if (wr && paddr == 12'h4d0) cfg_q <= pwdata[6:0];
      if (wr && paddr == 12'h51c) ph_q <= pwdata[7:0];
      hi_q <= gpio_out[0] ? hi_q + 8'h01 : 8'h00;
    end
  end

  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  err_rdata_a: assert property (psel && penable && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  restart_pulse_a: assert property (wr && paddr == 12'h07c && pwdata[14] |=> soft_restart ##1 !soft_restart)
    else $error("restart not a single pulse");
  restart_cause_a: assert property ($rose(soft_restart) |-> $past(wr && paddr == 12'h07c && pwdata[14]))
    else $error("restart without request");
  tx_delay_a: assert property (tx_delimiter_pulse_in && cfg_q[5] && mux_q[3:0] == 4'h2 && ph_q[3:0] == 4'h1 |-> ##4 gpio_out[0])
    else $error("tx delimiter pulse late or missing");
  rx_delay_a: assert property (rx_delimiter_pulse_in && cfg_q[5] && mux_q[7:4] == 4'h3 && ph_q[7:4] == 4'h0 |-> ##2 gpio_out[1])
    else $error("rx delimiter pulse late or missing");
  gate_off_a: assert property (!cfg_q[5] && $past(!cfg_q[5]) && mux_q[7:4] == 4'h3 |-> !gpio_out[1])
    else $error("delimiter pulse with feature off");
  wake_cause_a: assert property ($rose(gpio_out[0]) && mux_q[3:0] == 4'h1 |-> $past(rx_valid && rx_eof, 2))
    else $error("wake pin without frame end");
  pulse_len_a: assert property ($fell(gpio_out[0]) && mux_q[3:0] == 4'h1 && !cfg_q[6] |-> hi_q == PULSE_CYCLES)
    else $error("wake pulse width wrong");
endmodule
